//--- verilog/drt_pkg.sv
// Purpose: Constants and types for the three-instance timer/PWM/capture block
// Assumes: 100 MHz bus clock, classic Wishbone register access
// Notes: Register offsets are byte addresses of 32-bit words
package drt_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned NUM_TIMERS = 3;
  localparam int unsigned CNT_W = 16;
  // Counting rates: instruction tick and fast tick dividers in clk cycles
  localparam int unsigned INSTR_DIV = 10;
  localparam int unsigned FAST_DIV = 1;
  localparam logic [3:0] INSTR_DIV_M1 = 4'h9;
  // Per-timer register block stride and offsets, then the shared fast select register offset and reset value
  localparam logic [7:0] TMR_STRIDE = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_RC_A = 8'h08;
  localparam logic [7:0] OFF_RC_B = 8'h0c;
  localparam logic [7:0] OFF_FAST_SEL = 8'h30;
  localparam logic [7:0] FAST_SEL_RESET = 8'h00;
  // Control register fields
  localparam int unsigned CB_RUN = 0;
  localparam int unsigned CB_MODE_LO = 1;
  localparam int unsigned CB_PEND_A = 4;
  localparam int unsigned CB_EN_A = 5;
  localparam int unsigned CB_PEND_B = 6;
  localparam int unsigned CB_EN_B = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Mode codes, mode_select_bit2 first
  typedef enum logic [2:0] {
    DRT_EVT_RISE = 3'b000,
    DRT_EVT_FALL = 3'b001,
    DRT_CAP_RR = 3'b010,
    DRT_CAP_FR = 3'b011,
    DRT_PWM_PLAIN = 3'b100,
    DRT_PWM_TOGGLE = 3'b101,
    DRT_CAP_RF = 3'b110,
    DRT_CAP_FF = 3'b111
  } drt_mode_t;
  typedef struct packed {
    logic irq_enable_b;
    logic pending_flag_b;
    logic irq_enable_a;
    logic pending_flag_a;
    logic [2:0] mode;
    logic run_or_underflow_flag;
  } drt_ctrl_t;
  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } drt_wreq_t;
endpackage

//--- verilog/drt_timer.sv
// Purpose: One 16-bit timer instance with reload/capture registers
// Assumes: tick_i marks the selected counting rate
// Notes: Counter and reload registers are not reset
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module drt_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic pin_a_i,
  input wire logic pin_b_i,
  input wire logic ctrl_we_i,
  input wire logic cnt_we_i,
  input wire logic rca_we_i,
  input wire logic rcb_we_i,
  input wire logic [7:0] wdat_i,
  input wire logic [15:0] wdat16_i,
  output drt_pkg::drt_ctrl_t ctrl_o,
  output logic [15:0] count_o,
  output logic [15:0] rc_a_o,
  output logic [15:0] rc_b_o,
  output logic pin_a_o,
  output logic pin_a_oe_o,
  output logic irq_a_o,
  output logic irq_b_o
);
  drt_pkg::drt_ctrl_t ctrl_q;
  logic [15:0] count_q;
  logic [15:0] rc_a_q;
  logic [15:0] rc_b_q;
  logic next_b_q;
  logic pin_a_q;
  logic a_s1_q, a_s2_q, a_s3_q;
  logic b_s1_q, b_s2_q, b_s3_q;
  logic a_prev_q, b_prev_q;
  logic is_pwm, is_evt, is_cap, toggle_en;
  logic a_rise, a_fall, b_rise, b_fall, a_edge, b_edge, evt_step, step, uflow;
  logic cnt_known_q;
  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    is_pwm = ctrl_q.mode[2] && !ctrl_q.mode[1];
    is_evt = !ctrl_q.mode[2] && !ctrl_q.mode[1];
    is_cap = ctrl_q.mode[1];
    toggle_en = is_pwm && ctrl_q.mode[0];
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, sampled at the counting rate
  always_ff @(posedge clk_i) begin
    a_s1_q <= pin_a_i;
    a_s2_q <= a_s1_q;
    b_s1_q <= pin_b_i;
    b_s2_q <= b_s1_q;
    if (tick_i) begin
      a_s3_q <= a_s2_q;
      b_s3_q <= b_s2_q;
      a_prev_q <= a_s3_q;
      b_prev_q <= b_s3_q;
    end
  end
  always_comb begin
    a_rise = tick_i && a_s3_q && !a_prev_q;
    a_fall = tick_i && !a_s3_q && a_prev_q;
    b_rise = tick_i && b_s3_q && !b_prev_q;
    b_fall = tick_i && !b_s3_q && b_prev_q;
    a_edge = ctrl_q.mode[0] ? a_fall : a_rise;
    b_edge = ctrl_q.mode[2] ? b_fall : b_rise;
    evt_step = ctrl_q.mode[0] ? a_fall : a_rise;
    step = is_cap ? tick_i :
      (ctrl_q.run_or_underflow_flag && (is_evt ? evt_step : tick_i));
    uflow = step && (count_q == 16'h0000);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Counter and reload/capture registers
  always_ff @(posedge clk_i) begin
    if (cnt_we_i) begin
      count_q <= wdat16_i;
    end else if (uflow && is_pwm) begin
      count_q <= next_b_q ? rc_b_q : rc_a_q;
    end else if (step) begin
      count_q <= count_q - 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (is_cap && a_edge) begin
      rc_a_q <= count_q;
    end else if (rca_we_i) begin
      rc_a_q <= wdat16_i;
    end
    if (is_cap && b_edge) begin
      rc_b_q <= count_q;
    end else if (rcb_we_i) begin
      rc_b_q <= wdat16_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Reload alternation and PWM pin
  always_ff @(posedge clk_i) begin
    if (rst_i || !is_pwm || (ctrl_we_i && !wdat_i[drt_pkg::CB_RUN])) begin
      next_b_q <= 1'b0;
    end else if (uflow) begin
      next_b_q <= !next_b_q;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_q <= 1'b0;
    end else if (uflow && toggle_en) begin
      pin_a_q <= !pin_a_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Control register with sticky flags; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= drt_pkg::CTRL_RESET;
    end else begin
      if (ctrl_we_i) begin
        ctrl_q <= wdat_i;
      end
      if (is_cap && uflow) begin
        ctrl_q.run_or_underflow_flag <= 1'b1;
      end
      if ((is_pwm && uflow && !next_b_q) || (is_evt && uflow) || (is_cap && a_edge)) begin
        ctrl_q.pending_flag_a <= 1'b1;
      end
      if ((is_pwm && uflow && next_b_q) || (is_evt && b_rise) || (is_cap && b_edge)) begin
        ctrl_q.pending_flag_b <= 1'b1;
      end
    end
  end
  always_comb begin
    ctrl_o = ctrl_q;
    count_o = count_q;
    rc_a_o = rc_a_q;
    rc_b_o = rc_b_q;
    pin_a_o = pin_a_q;
    pin_a_oe_o = is_pwm;
    irq_a_o = ctrl_q.irq_enable_a && (ctrl_q.pending_flag_a ||
      (is_cap && ctrl_q.run_or_underflow_flag));
    irq_b_o = ctrl_q.irq_enable_b && ctrl_q.pending_flag_b;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Counter holds no defined value until software first loads it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_known_q <= 1'b0;
    end else if (cnt_we_i) begin
      cnt_known_q <= 1'b1;
    end
  end
  sequence s_pwm_a_reload;
    is_pwm && uflow && !next_b_q;
  endsequence
  a_reload_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pwm_a_reload |=> ctrl_q.pending_flag_a) else $error("pend a not set");
  a_reload_value: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_pwm_a_reload and !cnt_we_i) |=> count_q == $past(rc_a_q)) else $error("bad reload");
  a_alternation: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_pwm_a_reload and !ctrl_we_i) |=> next_b_q) else $error("no alternation");
  a_toggle_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    uflow && toggle_en |=> pin_a_q != $past(pin_a_q)) else $error("no toggle");
  a_no_drive_evt: assert property (@(posedge clk_i) disable iff (rst_i)
    is_evt |-> !pin_a_oe_o) else $error("pin driven in event mode");
  a_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_known_q && !is_cap && !ctrl_q.run_or_underflow_flag && !cnt_we_i |=>
    count_q == $past(count_q))
    else $error("stopped counter moved");
  a_capture_value: assert property (@(posedge clk_i) disable iff (rst_i)
    is_cap && a_edge |=> rc_a_q == $past(count_q)) else $error("bad capture");
  a_cap_uflow: assert property (@(posedge clk_i) disable iff (rst_i)
    is_cap && uflow |=> ctrl_q.run_or_underflow_flag) else $error("underflow lost");
  a_irq_b_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q.irq_enable_b |-> !irq_b_o) else $error("irq b ungated");
endmodule // drt_timer
`default_nettype wire

//--- verilog/drt_top.sv
// Purpose: Three timer instances behind a classic Wishbone slave
// Assumes: Pins synchronous to clk_i; counting ticks derived from clk_i
// Notes: Unmapped addresses read zero and are acknowledged
`timescale 1ns/1ns
`default_nettype none
module drt_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [2:0] timer_pin_a_i,
  output logic [2:0] timer_pin_a_o,
  output logic [2:0] timer_pin_a_oe_o,
  input wire logic [2:0] timer_pin_b_i,
  output logic [2:0] irq_a_o,
  output logic [2:0] irq_b_o
);
  drt_pkg::drt_wreq_t req;
  logic [3:0] div_q;
  logic instr_tick;
  logic [7:0] fast_sel_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic acc;
  drt_pkg::drt_ctrl_t ctrl [3];
  logic [15:0] cnt [3];
  logic [15:0] rca [3];
  logic [15:0] rcb [3];
  logic [2:0] tick;
  logic [2:0] ctrl_we, cnt_we, rca_we, rcb_we;
  ////////////////////////////////////////////////////////////////////////////
  // Request capture and instruction-rate tick
  always_comb begin
    req.adr = adr_i;
    req.we = we_i;
    req.sel = sel_i;
    req.dat = dat_i;
    acc = cyc_i && stb_i && !ack_q;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || div_q == drt_pkg::INSTR_DIV_M1) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign instr_tick = (div_q == drt_pkg::INSTR_DIV_M1);
  ////////////////////////////////////////////////////////////////////////////
  // Timer instances
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_tmr
      logic [7:0] base;
      assign base = drt_pkg::TMR_STRIDE * 8'(g);
      // First timer stays on the instruction rate
      if (g == 0) begin : g_slow
        assign tick[g] = instr_tick;
      end else begin : g_sel
        assign tick[g] = fast_sel_q[g-1] ? 1'b1 : instr_tick;
      end
      always_comb begin
        ctrl_we[g] = acc && req.we && req.sel[0] && req.adr == base + drt_pkg::OFF_CTRL;
        cnt_we[g] = acc && req.we && (&req.sel[1:0]) && req.adr == base + drt_pkg::OFF_COUNT;
        rca_we[g] = acc && req.we && (&req.sel[1:0]) && req.adr == base + drt_pkg::OFF_RC_A;
        rcb_we[g] = acc && req.we && (&req.sel[1:0]) && req.adr == base + drt_pkg::OFF_RC_B;
      end
      drt_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick[g]),
        .pin_a_i(timer_pin_a_i[g]),
        .pin_b_i(timer_pin_b_i[g]),
        .ctrl_we_i(ctrl_we[g]),
        .cnt_we_i(cnt_we[g]),
        .rca_we_i(rca_we[g]),
        .rcb_we_i(rcb_we[g]),
        .wdat_i(req.dat[7:0]),
        .wdat16_i(req.dat[15:0]),
        .ctrl_o(ctrl[g]),
        .count_o(cnt[g]),
        .rc_a_o(rca[g]),
        .rc_b_o(rcb[g]),
        .pin_a_o(timer_pin_a_o[g]),
        .pin_a_oe_o(timer_pin_a_oe_o[g]),
        .irq_a_o(irq_a_o[g]),
        .irq_b_o(irq_b_o[g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // Fast clock select register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_sel_q <= drt_pkg::FAST_SEL_RESET;
    end else if (acc && req.we && req.sel[0] && req.adr == drt_pkg::OFF_FAST_SEL) begin
      fast_sel_q <= {6'h00, req.dat[1:0]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      rdat_q <= 32'h0000_0000;
      if (acc && !req.we) begin
        if (req.adr == drt_pkg::OFF_FAST_SEL) begin
          rdat_q <= {24'h000000, fast_sel_q};
        end
        for (int i = 0; i < 3; i++) begin
          if (req.adr == drt_pkg::TMR_STRIDE * i[7:0] + drt_pkg::OFF_CTRL) begin
            rdat_q <= {24'h000000, ctrl[i]};
          end else if (req.adr == drt_pkg::TMR_STRIDE * i[7:0] + drt_pkg::OFF_COUNT) begin
            rdat_q <= {16'h0000, cnt[i]};
          end else if (req.adr == drt_pkg::TMR_STRIDE * i[7:0] + drt_pkg::OFF_RC_A) begin
            rdat_q <= {16'h0000, rca[i]};
          end else if (req.adr == drt_pkg::TMR_STRIDE * i[7:0] + drt_pkg::OFF_RC_B) begin
            rdat_q <= {16'h0000, rcb[i]};
          end
        end
      end
    end
  end
  assign ack_o = ack_q;
  assign dat_o = rdat_q;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  a_first_slow: assert property (@(posedge clk_i) disable iff (rst_i)
    tick[0] |-> instr_tick) else $error("first timer fast");
endmodule // drt_top
`default_nettype wire

//--- dv/drt_pin_model.sv
// Purpose: Pin-side partner: signal sources on pins A and B, load on pin A
// Assumes: Bench sets source levels just after a clock edge
// Notes: Pin A level is resolved from the timer's and the source's drivers
`timescale 1ns/1ns
`default_nettype none
module drt_pin_model (
  input wire logic [2:0] pin_a_o,
  input wire logic [2:0] pin_a_oe_o,
  input wire logic [2:0] src_a_i,
  input wire logic [2:0] src_b_i,
  output logic [2:0] pin_a_i,
  output logic [2:0] pin_b_i
);
  ////////////////////////////////////////////////////////////////////////////
  // Source drives pin A only while the timer releases it
  assign pin_a_i = (pin_a_oe_o & pin_a_o) | (~pin_a_oe_o & src_a_i);
  assign pin_b_i = src_b_i;
endmodule // drt_pin_model
`default_nettype wire

//--- dv/test_dual_reload_timer_pwm_capture.sv
// Purpose: Register-level test of the three-timer block
// Assumes: One-cycle Wishbone answer, instruction tick every 10 clocks
// Notes: Timer 2 runs fast for the pin tests
`timescale 1ns/1ns
`default_nettype none
module test_dual_reload_timer_pwm_capture;
  logic clk_i, rst_i, cyc, stb, we, ack, p;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q, c0;
  logic [2:0] pa_i, pa_o, pa_oe, pb_i, ira, irb, src_a, src_b, code;
  logic [2:0] codes [4] = '{3'b010, 3'b110, 3'b011, 3'b111};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  drt_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .timer_pin_a_i(pa_i), .timer_pin_a_o(pa_o), .timer_pin_a_oe_o(pa_oe),
    .timer_pin_b_i(pb_i), .irq_a_o(ira), .irq_b_o(irb));
  drt_pin_model pins (.pin_a_o(pa_o), .pin_a_oe_o(pa_oe), .src_a_i(src_a),
    .src_b_i(src_b), .pin_a_i(pa_i), .pin_b_i(pb_i));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout, closing report
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle, compare, wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic w8(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    src_a = 3'h0;
    src_b = 3'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h00, 32'h0);
    rc(8'h30, 32'h0);
    bus(1'b1, 8'h3c, 32'hffffffff);
    rc(8'h3c, 32'h0);
    // Counting rate of each timer under two speed settings
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 8'h30, s ? 32'h1 : 32'hff);
      rc(8'h30, s ? 32'h1 : 32'h3);
      for (int t = 0; t < 3; t++) begin
        bus(1'b1, 8'(16 * t), 32'h0);
        bus(1'b1, 8'(16 * t + 4), 32'hffff);
        bus(1'b1, 8'(16 * t + 8), 32'hffff);
        bus(1'b1, 8'(16 * t + 12), 32'hffff);
        bus(1'b1, 8'(16 * t), 32'h09);
      end
      w8(200);
      for (int t = 0; t < 3; t++) bus(1'b1, 8'(16 * t), 32'h08);
      for (int t = 0; t < 3; t++) begin
        bus(1'b0, 8'(16 * t + 4), 32'h0);
        chk(32'hffff - q >= 32'h80, t == 1 || (t == 2 && s == 0));
      end
    end
    // Timer 0 PWM with toggle, both enables
    bus(1'b1, 8'h00, 32'h00);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h0c, 32'h2);
    bus(1'b1, 8'h00, 32'hab);
    while (ira[0] !== 1'b1) @(posedge clk_i);
    w8(2);
    p = pa_o[0];
    chk({irb[0], pa_oe[0]}, 2'b01);
    rc(8'h00, 32'hbb);
    while (irb[0] !== 1'b1) @(posedge clk_i);
    w8(2);
    chk(pa_o[0], !p);
    rc(8'h00, 32'hfb);
    bus(1'b1, 8'h00, 32'hab);
    chk({ira[0], irb[0]}, 2'b00);
    // Plain PWM keeps the pin level
    bus(1'b1, 8'h00, 32'h29);
    while (ira[0] !== 1'b1) @(posedge clk_i);
    w8(2);
    p = pa_o[0];
    w8(60);
    chk({pa_o[0], pa_oe[0]}, {p, 1'b1});
    bus(1'b1, 8'h00, 32'h09);
    w8(80);
    chk(ira[0] | irb[0], 1'b0);
    bus(1'b0, 8'h00, 32'h0);
    chk(q[6] & q[4], 1'b1);
    bus(1'b1, 8'h00, 32'h08);
    bus(1'b0, 8'h04, 32'h0);
    c0 = q;
    w8(30);
    rc(8'h04, c0);
    // Timer 2 fast, event counting on both polarities
    bus(1'b1, 8'h30, 32'h2);
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, 8'h24, 32'h5);
      bus(1'b1, 8'h20, 32'ha1 | (m << 1));
      src_a[2] <= 1'b1;
      w8(10);
      rc(8'h24, m ? 32'h5 : 32'h4);
      src_a[2] <= 1'b0;
      w8(10);
      rc(8'h24, 32'h4);
    end
    chk({pa_oe[2], ira[2]}, 2'b00);
    repeat (5) begin
      src_a[2] <= 1'b1;
      w8(6);
      src_a[2] <= 1'b0;
      w8(6);
    end
    chk({ira[2], irb[2]}, 2'b10);
    src_b[2] <= 1'b1;
    w8(10);
    chk(irb[2], 1'b1);
    // Capture with each polarity pair
    foreach (codes[i]) begin
      code = codes[i];
      src_a[2] <= !code[0];
      src_b[2] <= !code[2];
      bus(1'b1, 8'h24, 32'h800);
      w8(10);
      bus(1'b1, 8'h20, 32'ha0 | {code, 1'b0});
      src_a[2] <= code[0];
      src_b[2] <= code[2];
      w8(10);
      rc(8'h20, 32'ha0 | {code, 1'b0});
      bus(1'b0, 8'h24, 32'h0);
      c0 = q;
      src_a[2] <= !code[0];
      w8(10);
      rc(8'h20, 32'hb0 | {code, 1'b0});
      bus(1'b0, 8'h28, 32'h0);
      chk(c0 - q < 32'h40, 1'b1);
      rc(8'h28, q);
      bus(1'b0, 8'h24, 32'h0);
      chk(q < c0 - 32'h8, 1'b1);
      src_b[2] <= !code[2];
      w8(10);
      rc(8'h20, 32'hf0 | {code, 1'b0});
      chk({ira[2], irb[2]}, 2'b11);
    end
    bus(1'b1, 8'h20, 32'h2e);
    chk(ira[2], 1'b0);
    bus(1'b1, 8'h24, 32'h4);
    w8(20);
    rc(8'h20, 32'h2f);
    chk(ira[2], 1'b1);
    end_of_test();
  end
endmodule // test_dual_reload_timer_pwm_capture
`default_nettype wire
